/* src/dspi_cfg.svh */
// Purpose: constants of the dual serial register access slave
// Assumes: included by bare name; definitions only
// Notes:   command codes are the 3-bit field of the header
`ifndef DSPI_CFG_SVH
`define DSPI_CFG_SVH

// command field codes
`define DSPI_CMD_NOP      3'h0
`define DSPI_CMD_RD       3'h2
`define DSPI_CMD_RDW      3'h3
`define DSPI_CMD_WR       3'h4
`define DSPI_CMD_EXT      3'h6

// header field positions
`define DSPI_H0_ADDR_HI   12
`define DSPI_H0_ADDR_LO   5
`define DSPI_H1_ADDR_W    5
`define DSPI_H2_ADDR_LO   13

// short header reach, top 3 address bits forced to zero
`define DSPI_SHORT_LIMIT  16'h2000

// the master's final read byte, after which no prefetch is made
`define DSPI_LAST_RD_BYTE 8'hFF
`define DSPI_ZERO_BYTE    8'h00

// synchroniser layout and reset value (selects and clocks idle high)
`define DSPI_SYNC_W       7
`define DSPI_SYNC_RST     7'h36
`define DSPI_BIT_MSIN     0
`define DSPI_BIT_MSCK     1
`define DSPI_BIT_MSEL     2
`define DSPI_BIT_ISIN     3
`define DSPI_BIT_ISCK     4
`define DSPI_BIT_ISEL     5
`define DSPI_BIT_STRAP    6

// least pause the master leaves before plain read data
`define DSPI_CLK_NS       25
`define DSPI_FETCH_NS     240
// rounded up so a whole-cycle pause never falls short of the fetch time
`define DSPI_FETCH_CYC    (((`DSPI_FETCH_NS) + (`DSPI_CLK_NS) - 1) / (`DSPI_CLK_NS))

`endif

/* src/dspi_pkg.sv */
// Purpose: types of the dual serial register access slave
// Assumes: dspi_cfg.svh holds the numeric constants
// Notes:   all module state lives in the packed structs below
`include "dspi_cfg.svh"

package dspi_pkg;

    typedef enum logic [2:0] {
        DSPI_HDR0,
        DSPI_HDR1,
        DSPI_HDR2,
        DSPI_WAIT,
        DSPI_DATA,
        DSPI_IGNORE
    } dspi_phase_t;

    typedef struct packed {
        dspi_phase_t phase;
        logic [2:0]  bitcnt;
        logic [7:0]  sh_in;
        logic [7:0]  sh_out;
        logic [15:0] addr;
        logic [2:0]  cmd;
        logic        sck_q;
        logic        rd;
        logic        wr;
        logic [15:0] mem_addr;
        logic [7:0]  wdata;
        logic        wdog;
    } dspi_port_t;

    typedef struct packed {
        dspi_port_t [1:0] p;
        logic             main_out;
        logic             io_out;
    } dspi_state_t;

    typedef struct packed {
        logic [`DSPI_SYNC_W-1:0] s1;
        logic [`DSPI_SYNC_W-1:0] s2;
    } dspi_sync_t;

endpackage

/* src/dspi_pin_if.sv */
// Purpose: synchronised pin levels passed from the synchroniser to the core
// Assumes: every signal is already in the i_mclk domain
// Notes:   one producer, one consumer
`timescale 1ns/1ps

interface dspi_pin_if;
    logic main_sel_n;
    logic main_sck;
    logic main_sin;
    logic io_sel_n;
    logic io_sck;
    logic io_sin;
    logic strap;

    modport sync_mp (output main_sel_n, main_sck, main_sin, io_sel_n, io_sck, io_sin, strap);
    modport core_mp (input  main_sel_n, main_sck, main_sin, io_sel_n, io_sck, io_sin, strap);
endinterface

/* src/dspi_pin_sync.sv */
// Purpose: two-flop synchroniser for every pin of both serial ports
// Assumes: pins are asynchronous to i_mclk
// Notes:   first stage feeds the second stage only
`timescale 1ns/1ps
`include "dspi_cfg.svh"

module dspi_pin_sync (
    input  wire logic        i_mclk,
    input  wire logic        i_arst_n,
    input  wire logic        i_main_port_select_n,
    input  wire logic        i_main_serial_clock,
    input  wire logic        i_main_serial_in,
    input  wire logic        i_io_ctrl_select_n,
    input  wire logic        i_io_ctrl_serial_clock,
    input  wire logic        i_io_ctrl_serial_in,
    input  wire logic        i_shared_bus_strap,
    dspi_pin_if.sync_mp      o_pins
);

    dspi_pkg::dspi_sync_t    sync_r;
    dspi_pkg::dspi_sync_t    sync_nxt;
    logic [`DSPI_SYNC_W-1:0] raw;

    // gather pins in the order of the bit positions
    assign raw = {i_shared_bus_strap, i_io_ctrl_select_n, i_io_ctrl_serial_clock,
                  i_io_ctrl_serial_in, i_main_port_select_n, i_main_serial_clock,
                  i_main_serial_in};

    // stage one samples, stage two is the only reader of stage one
    always_comb begin
        sync_nxt    = sync_r;
        sync_nxt.s1 = raw;
        sync_nxt.s2 = sync_r.s1;
    end

    // idle values so no false edge or select shows after reset
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync_r <= {`DSPI_SYNC_RST, `DSPI_SYNC_RST};
        end else begin
            sync_r <= sync_nxt;
        end
    end

    assign o_pins.main_sin   = sync_r.s2[`DSPI_BIT_MSIN];
    assign o_pins.main_sck   = sync_r.s2[`DSPI_BIT_MSCK];
    assign o_pins.main_sel_n = sync_r.s2[`DSPI_BIT_MSEL];
    assign o_pins.io_sin     = sync_r.s2[`DSPI_BIT_ISIN];
    assign o_pins.io_sck     = sync_r.s2[`DSPI_BIT_ISCK];
    assign o_pins.io_sel_n   = sync_r.s2[`DSPI_BIT_ISEL];
    assign o_pins.strap      = sync_r.s2[`DSPI_BIT_STRAP];

endmodule

/* src/dspi_top.sv */
// Purpose: two serial slave ports giving byte access to the controller
//          core memory (port 0) and to the I/O block registers (port 1)
// Assumes: serial clock slow enough for 4+ i_mclk samples per half period
// Notes:   memory answers i_*_rdata in the same cycle as the read strobe
`timescale 1ns/1ps
`include "dspi_cfg.svh"

module dspi_top (
    input  wire logic        i_mclk,
    input  wire logic        i_arst_n,
    input  wire logic        i_shared_bus_strap,
    input  wire logic        i_main_port_select_n,
    input  wire logic        i_main_serial_clock,
    input  wire logic        i_main_serial_in,
    output logic             o_main_serial_out,
    input  wire logic        i_io_ctrl_select_n,
    input  wire logic        i_io_ctrl_serial_clock,
    input  wire logic        i_io_ctrl_serial_in,
    output logic             o_io_ctrl_serial_out,
    input  wire logic [23:0] i_pd_event,
    input  wire logic [7:0]  i_pd_rdata,
    output logic             o_pd_rd,
    output logic             o_pd_wr,
    output logic [15:0]      o_pd_addr,
    output logic [7:0]       o_pd_wdata,
    output logic             o_pd_wdog_restart,
    input  wire logic [23:0] i_io_event,
    input  wire logic [7:0]  i_io_rdata,
    output logic             o_io_rd,
    output logic             o_io_wr,
    output logic [15:0]      o_io_addr,
    output logic [7:0]       o_io_wdata,
    output logic             o_io_nop_seen
);

    dspi_pin_if              pins ();
    dspi_pkg::dspi_state_t   st_r;
    dspi_pkg::dspi_state_t   st_nxt;
    logic [1:0]              sel_n;
    logic [1:0]              sck;
    logic [1:0]              sin;
    logic [1:0][23:0]        ev;
    logic [1:0][7:0]         rdata;

    // extension code test, used for the second and third header byte
    function automatic logic dspi_is_ext(input logic [2:0] code);
        dspi_is_ext = (code == `DSPI_CMD_EXT);
    endfunction

    dspi_pin_sync u_sync (
        .i_mclk                 (i_mclk),
        .i_arst_n               (i_arst_n),
        .i_main_port_select_n   (i_main_port_select_n),
        .i_main_serial_clock    (i_main_serial_clock),
        .i_main_serial_in       (i_main_serial_in),
        .i_io_ctrl_select_n     (i_io_ctrl_select_n),
        .i_io_ctrl_serial_clock (i_io_ctrl_serial_clock),
        .i_io_ctrl_serial_in    (i_io_ctrl_serial_in),
        .i_shared_bus_strap     (i_shared_bus_strap),
        .o_pins                 (pins.sync_mp)
    );

    // pin routing: shared mode feeds the I/O engine from the main wires
    assign sel_n[0] = pins.main_sel_n;
    assign sck[0]   = pins.main_sck;
    assign sin[0]   = pins.main_sin;
    assign sel_n[1] = pins.io_sel_n;
    assign sck[1]   = pins.strap ? pins.main_sck : pins.io_sck;
    assign sin[1]   = pins.strap ? pins.main_sin : pins.io_sin;
    assign ev[0]    = i_pd_event;
    assign ev[1]    = i_io_event;
    assign rdata[0] = i_pd_rdata;
    assign rdata[1] = i_io_rdata;

    // both engines are identical; no network state gates the I/O one
    always_comb begin
        logic [7:0] b;
        logic       rise;
        logic       fall;
        logic       go;
        logic [2:0] cv;
        b      = `DSPI_ZERO_BYTE;
        rise   = 1'b0;
        fall   = 1'b0;
        go     = 1'b0;
        cv     = `DSPI_CMD_NOP;
        st_nxt = st_r;
        for (int k = 0; k < 2; k++) begin
            st_nxt.p[k].rd    = 1'b0;
            st_nxt.p[k].wr    = 1'b0;
            st_nxt.p[k].wdog  = 1'b0;
            st_nxt.p[k].sck_q = sck[k];
            // mode 3: sample on rising, shift out on falling edge
            rise = sck[k] & ~st_r.p[k].sck_q;
            fall = ~sck[k] & st_r.p[k].sck_q;
            go   = 1'b0;
            cv   = `DSPI_CMD_NOP;
            b    = {st_r.p[k].sh_in[6:0], sin[k]};
            if (sel_n[k]) begin
                // released select ends the datagram, next one starts fresh
                st_nxt.p[k].phase  = dspi_pkg::DSPI_HDR0;
                st_nxt.p[k].bitcnt = 3'h0;
                st_nxt.p[k].sh_out = ev[k][7:0];
            end else begin
                // fetched byte lands the cycle after the strobe
                if (st_r.p[k].rd) begin
                    st_nxt.p[k].sh_out = rdata[k];
                end
                if (fall && st_r.p[k].bitcnt != 3'h0) begin
                    st_nxt.p[k].sh_out = {st_r.p[k].sh_out[6:0], 1'b0};
                end
                // bytes are taken back to back, no gap required
                if (rise) begin
                    st_nxt.p[k].sh_in  = b;
                    st_nxt.p[k].bitcnt = st_r.p[k].bitcnt + 3'h1;
                end
                if (rise && st_r.p[k].bitcnt == 3'h7) begin
                    st_nxt.p[k].sh_out = `DSPI_ZERO_BYTE;
                    case (st_r.p[k].phase)
                        dspi_pkg::DSPI_HDR0: begin
                            // top bits zero: short header stays below 0x2000
                            st_nxt.p[k].addr  = {3'h0, b, 5'h00};
                            st_nxt.p[k].phase = dspi_pkg::DSPI_HDR1;
                            st_nxt.p[k].sh_out = ev[k][15:8];
                        end
                        dspi_pkg::DSPI_HDR1: begin
                            st_nxt.p[k].addr[`DSPI_H1_ADDR_W-1:0] = b[7:3];
                            if (dspi_is_ext(b[2:0])) begin
                                st_nxt.p[k].phase  = dspi_pkg::DSPI_HDR2;
                                st_nxt.p[k].sh_out = ev[k][23:16];
                            end else begin
                                go = 1'b1;
                                cv = b[2:0];
                            end
                        end
                        dspi_pkg::DSPI_HDR2: begin
                            // long header reaches the full map; repeats accepted
                            st_nxt.p[k].addr[15:`DSPI_H2_ADDR_LO] = b[7:5];
                            if (dspi_is_ext(b[4:2])) begin
                                st_nxt.p[k].sh_out = ev[k][23:16];
                            end else begin
                                go = 1'b1;
                                cv = b[4:2];
                            end
                        end
                        dspi_pkg::DSPI_WAIT: begin
                            // dummy byte ignored; fetch starts now
                            st_nxt.p[k].phase    = dspi_pkg::DSPI_DATA;
                            st_nxt.p[k].rd       = 1'b1;
                            st_nxt.p[k].mem_addr = st_r.p[k].addr;
                        end
                        dspi_pkg::DSPI_DATA: begin
                            st_nxt.p[k].addr = st_r.p[k].addr + 16'h0001;
                            if (st_r.p[k].cmd == `DSPI_CMD_WR) begin
                                st_nxt.p[k].wr       = 1'b1;
                                st_nxt.p[k].mem_addr = st_r.p[k].addr;
                                st_nxt.p[k].wdata    = b;
                            end else if (b != `DSPI_LAST_RD_BYTE) begin
                                // 0xFF marks the last byte: skip the prefetch
                                st_nxt.p[k].rd       = 1'b1;
                                st_nxt.p[k].mem_addr = st_r.p[k].addr + 16'h0001;
                            end
                        end
                        default: begin
                            st_nxt.p[k].phase = dspi_pkg::DSPI_IGNORE;
                        end
                    endcase
                end
                // execute the decoded command
                if (go) begin
                    st_nxt.p[k].cmd = cv;
                    case (cv)
                        `DSPI_CMD_NOP: begin
                            st_nxt.p[k].phase = dspi_pkg::DSPI_IGNORE;
                            st_nxt.p[k].wdog  = 1'b1;
                        end
                        `DSPI_CMD_RD: begin
                            // fetch must finish inside the master's pause
                            st_nxt.p[k].phase    = dspi_pkg::DSPI_DATA;
                            st_nxt.p[k].rd       = 1'b1;
                            st_nxt.p[k].mem_addr = st_nxt.p[k].addr;
                            st_nxt.p[k].wdog     = 1'b1;
                        end
                        `DSPI_CMD_RDW: begin
                            st_nxt.p[k].phase = dspi_pkg::DSPI_WAIT;
                            st_nxt.p[k].wdog  = 1'b1;
                        end
                        `DSPI_CMD_WR: begin
                            st_nxt.p[k].phase = dspi_pkg::DSPI_DATA;
                            st_nxt.p[k].wdog  = 1'b1;
                        end
                        default: begin
                            // reserved codes touch no memory
                            st_nxt.p[k].phase = dspi_pkg::DSPI_IGNORE;
                        end
                    endcase
                end
            end
        end
        // shared mode: the main output wire carries whichever port is selected
        if (pins.strap && !sel_n[1]) begin
            st_nxt.main_out = st_r.p[1].sh_out[7];
        end else begin
            st_nxt.main_out = st_r.p[0].sh_out[7];
        end
        st_nxt.io_out = pins.strap ? 1'b1 : st_r.p[1].sh_out[7];
    end

    // single state register; outputs below come straight from it
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_r <= '0;
            st_r.p[0].sck_q <= 1'b1;
            st_r.p[1].sck_q <= 1'b1;
            st_r.main_out   <= 1'b1;
            st_r.io_out     <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_main_serial_out    = st_r.main_out;
    assign o_io_ctrl_serial_out = st_r.io_out;
    assign o_pd_rd              = st_r.p[0].rd;
    assign o_pd_wr              = st_r.p[0].wr;
    assign o_pd_addr            = st_r.p[0].mem_addr;
    assign o_pd_wdata           = st_r.p[0].wdata;
    assign o_pd_wdog_restart    = st_r.p[0].wdog;
    assign o_io_rd              = st_r.p[1].rd;
    assign o_io_wr              = st_r.p[1].wr;
    assign o_io_addr            = st_r.p[1].mem_addr;
    assign o_io_wdata           = st_r.p[1].wdata;
    assign o_io_nop_seen        = st_r.p[1].wdog;

endmodule

/* bench/dspi_top_checker.sv */
// Purpose: port-level assertions for the dual serial access slave
// Assumes: one clock domain, i_mclk, async active-low reset
// Notes:   quiet windows count raw select-high cycles, past sync lag
`timescale 1ns/1ps

module dspi_top_checker (
    input  wire logic        i_mclk,
    input  wire logic        i_arst_n,
    input  wire logic        i_shared_bus_strap,
    input  wire logic        i_main_port_select_n,
    input  wire logic        i_io_ctrl_select_n,
    input  wire logic [23:0] i_pd_event,
    input  wire logic [23:0] i_io_event,
    input  wire logic        o_main_serial_out,
    input  wire logic        o_io_ctrl_serial_out,
    input  wire logic        o_pd_rd,
    input  wire logic        o_pd_wr,
    input  wire logic [15:0] o_pd_addr,
    input  wire logic        o_pd_wdog_restart,
    input  wire logic        o_io_rd,
    input  wire logic        o_io_wr,
    input  wire logic        o_io_nop_seen
);
    logic [3:0] pd_idle_r;
    logic [3:0] io_idle_r;

    // saturating count of cycles each select has stood high
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pd_idle_r <= 4'h0;
            io_idle_r <= 4'h0;
        end else begin
            pd_idle_r <= i_main_port_select_n ? pd_idle_r + 4'(pd_idle_r != 4'hF) : 4'h0;
            io_idle_r <= i_io_ctrl_select_n ? io_idle_r + 4'(io_idle_r != 4'hF) : 4'h0;
        end
    end

    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);

    pd_rd_pulse_a:
        assert property (o_pd_rd |=> !o_pd_rd) else $error("read strobe too long");
    pd_wr_pulse_a:
        assert property (o_pd_wr |=> !o_pd_wr) else $error("write strobe too long");
    io_wr_pulse_a:
        assert property (o_io_wr |=> !o_io_wr) else $error("io write strobe too long");
    pd_quiet_a:
        assert property (pd_idle_r >= 4'h8 |-> !(o_pd_rd || o_pd_wr || o_pd_wdog_restart))
        else $error("main port active while deselected");
    io_quiet_a:
        assert property (io_idle_r >= 4'h8 |-> !(o_io_rd || o_io_wr || o_io_nop_seen))
        else $error("io port active while deselected");
    pd_addr_hold_a:
        assert property ($changed(o_pd_addr) |-> (o_pd_rd || o_pd_wr))
        else $error("address moved without a strobe");
    pd_idle_out_a:
        assert property ((i_main_port_select_n && i_io_ctrl_select_n && $stable(i_pd_event))[*8]
            |-> o_main_serial_out == i_pd_event[7]) else $error("main idle bit not event msb");
    io_idle_out_a:
        assert property ((i_io_ctrl_select_n && !i_shared_bus_strap && $stable(i_io_event))[*8]
            |-> o_io_ctrl_serial_out == i_io_event[7]) else $error("io idle bit not event msb");
    io_shared_out_a:
        assert property (i_shared_bus_strap[*6] |-> o_io_ctrl_serial_out)
        else $error("io output pin driven in shared mode");
endmodule

/* bench/dspi_spi_master.sv */
// Purpose: mode 3 serial master standing for the local controller
// Assumes: moves only on i_clk falling edges, 200 ns serial period
// Notes:   unused data pins carry a toggling pattern, never a held value
`timescale 1ns/1ps

module dspi_spi_master (
    input  wire logic       i_clk,
    input  wire logic       i_shared,
    input  wire logic       i_main_sout,
    input  wire logic       i_io_sout,
    output logic            o_main_sel_n,
    output logic            o_main_sck,
    output logic            o_main_sin,
    output logic            o_io_sel_n,
    output logic            o_io_sck,
    output logic            o_io_sin,
    output logic [7:0]      o_rx,
    output logic            o_rx_done
);
    logic busy, io_sel, sck_v, sin_v, noise, use_io;

    // pin routing; clocks idle high outside frames, except the io clock, which toggles in shared mode
    assign use_io       = io_sel && !i_shared;
    assign o_main_sel_n = !(busy && !io_sel);
    assign o_io_sel_n   = !(busy && io_sel);
    assign o_main_sck   = (busy && !use_io) ? sck_v : 1'b1;
    assign o_io_sck     = i_shared ? noise : ((busy && use_io) ? sck_v : 1'b1);
    assign o_main_sin   = (busy && !use_io) ? sin_v : noise;
    assign o_io_sin     = (busy && use_io) ? sin_v : noise;

    initial begin
        {busy, io_sel, sin_v, noise, o_rx_done} = 5'h00;
        sck_v = 1'b1;
        o_rx = 8'h00;
    end

    // released data lines must not look like a held bit
    always @(negedge i_clk) noise <= ~noise;

    task automatic open_frame(input logic io);
        @(negedge i_clk);
        io_sel = io;
        busy = 1'b1;
        repeat (4) @(negedge i_clk);
    endtask

    // msb first; data set on falling, reply sampled before rising
    task automatic send(input logic [7:0] b, input int nb);
        for (int i = 7; i > 7 - nb; i--) begin
            sck_v = 1'b0;
            sin_v = b[i];
            repeat (4) @(negedge i_clk);
            o_rx[i] = use_io ? i_io_sout : i_main_sout;
            sck_v = 1'b1;
            repeat (4) @(negedge i_clk);
        end
        if (nb == 8) begin
            o_rx_done = 1'b1;
            @(negedge i_clk);
            o_rx_done = 1'b0;
        end
    endtask

    task automatic close_frame();
        busy = 1'b0;
        repeat (8) @(negedge i_clk);
    endtask
endmodule

/* bench/dspi_top_tb.sv */
// Purpose: self-checking bench for the dual serial access slave
// Assumes: memory answers in the same cycle as a read strobe
// Notes:   drivers queue expectations, watchers compare on arrival
`timescale 1ns/1ps
`include "dspi_cfg.svh"

module dspi_top_tb;
    logic        i_mclk, i_arst_n, i_shared_bus_strap, rx_done;
    logic        i_main_port_select_n, i_main_serial_clock, i_main_serial_in, o_main_serial_out;
    logic        i_io_ctrl_select_n, i_io_ctrl_serial_clock, i_io_ctrl_serial_in;
    logic        o_io_ctrl_serial_out, o_pd_rd, o_pd_wr, o_pd_wdog_restart;
    logic        o_io_rd, o_io_wr, o_io_nop_seen;
    logic [23:0] i_pd_event, i_io_event;
    logic [7:0]  i_pd_rdata, i_io_rdata, o_pd_wdata, o_io_wdata, rx_byte;
    logic [15:0] o_pd_addr, o_io_addr;
    logic [24:0] exp_wr[$];
    logic [8:0]  exp_rx[$];
    logic [8:0]  note;
    int          err_total, checks_done, cycles, wd_pd, wd_io, exp_pd, exp_io;
    int unsigned rnd;

    initial begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end

    dspi_top dut_u (.i_mclk, .i_arst_n, .i_shared_bus_strap, .i_main_port_select_n,
        .i_main_serial_clock, .i_main_serial_in, .o_main_serial_out, .i_io_ctrl_select_n,
        .i_io_ctrl_serial_clock, .i_io_ctrl_serial_in, .o_io_ctrl_serial_out, .i_pd_event,
        .i_pd_rdata, .o_pd_rd, .o_pd_wr, .o_pd_addr, .o_pd_wdata, .o_pd_wdog_restart,
        .i_io_event, .i_io_rdata, .o_io_rd, .o_io_wr, .o_io_addr, .o_io_wdata, .o_io_nop_seen);

    dspi_spi_master master_u (.i_clk(i_mclk), .i_shared(i_shared_bus_strap),
        .i_main_sout(o_main_serial_out), .i_io_sout(o_io_ctrl_serial_out),
        .o_main_sel_n(i_main_port_select_n), .o_main_sck(i_main_serial_clock),
        .o_main_sin(i_main_serial_in), .o_io_sel_n(i_io_ctrl_select_n),
        .o_io_sck(i_io_ctrl_serial_clock), .o_io_sin(i_io_ctrl_serial_in),
        .o_rx(rx_byte), .o_rx_done(rx_done));

    function automatic logic [7:0] mem_f(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction

    // memory for both ports; stale data is inverted, not held
    always @(negedge i_mclk) begin
        i_pd_rdata <= o_pd_rd ? mem_f(o_pd_addr) : ~i_pd_rdata;
        i_io_rdata <= o_io_rd ? mem_f(o_io_addr) : ~i_io_rdata;
    end

    task automatic stop_test();
        if (err_total == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // serial replies compared as each byte completes
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 30000) begin
            err_total++;
            stop_test();
        end else if (rx_done === 1'b1) begin
            if (exp_rx.size() == 0) chk(32'h1, 32'h0);
            else begin
                note = exp_rx.pop_front();
                if (!note[8]) chk(32'(rx_byte), 32'(note[7:0]));
            end
        end
    end

    // memory-side strobes sampled where settled
    always @(negedge i_mclk) begin
        if (o_pd_wr === 1'b1) chk(32'({1'b0, o_pd_addr, o_pd_wdata}),
            exp_wr.size() ? 32'(exp_wr.pop_front()) : 32'h1FFFFFF);
        if (o_io_wr === 1'b1) chk(32'({1'b1, o_io_addr, o_io_wdata}),
            exp_wr.size() ? 32'(exp_wr.pop_front()) : 32'h1FFFFFF);
        if (o_pd_wdog_restart === 1'b1) wd_pd++;
        if (o_io_nop_seen === 1'b1) wd_io++;
    end

    task automatic xfer(input logic [7:0] b, input logic [8:0] e);
        exp_rx.push_back(e);
        master_u.send(b, 8);
    endtask

    // one datagram; bit 8 of a reply note marks a byte of no interest
    task automatic dgram(input logic io, input logic [2:0] cmd, input logic [15:0] a,
                         input logic lng, input int pad, input int n);
        logic [23:0] ev;
        logic [15:0] ea;
        logic [7:0]  b;
        ev = io ? i_io_event : i_pd_event;
        ea = lng ? a : {3'h0, a[12:0]};
        if (cmd inside {`DSPI_CMD_NOP, `DSPI_CMD_RD, `DSPI_CMD_RDW, `DSPI_CMD_WR}) begin
            if (io) exp_io++;
            else exp_pd++;
        end
        master_u.open_frame(io);
        xfer(a[12:5], 9'(ev[7:0]));
        if (lng) begin
            xfer({a[4:0], `DSPI_CMD_EXT}, 9'(ev[15:8]));
            for (int i = 0; i < pad; i++)
                xfer({a[15:13], `DSPI_CMD_EXT, 2'b00}, 9'(ev[23:16]));
            xfer({a[15:13], cmd, 2'b00}, 9'(ev[23:16]));
        end else begin
            xfer({a[4:0], cmd}, 9'(ev[15:8]));
        end
        if (cmd == `DSPI_CMD_RD) repeat (`DSPI_FETCH_CYC + 2) @(negedge i_mclk);
        if (cmd == `DSPI_CMD_RDW) xfer(`DSPI_ZERO_BYTE, 9'h100);
        for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            if (cmd == `DSPI_CMD_WR) begin
                exp_wr.push_back({io, 16'(ea + i), b});
                xfer(b, 9'h000);
            end else if (cmd inside {`DSPI_CMD_RD, `DSPI_CMD_RDW}) begin
                b = (i == n - 1) ? `DSPI_LAST_RD_BYTE : `DSPI_ZERO_BYTE;
                xfer(b, 9'(mem_f(16'(ea + i))));
            end else xfer(b, 9'h100);
        end
        master_u.close_frame();
    endtask

    // main sequence
    initial begin
        i_arst_n = 1'b0;
        i_shared_bus_strap = 1'b0;
        i_pd_rdata = 8'h00;
        i_io_rdata = 8'h00;
        rnd = $urandom(61286);
        i_pd_event = 24'($urandom);
        i_io_event = 24'($urandom);
        repeat (8) @(posedge i_mclk);
        @(negedge i_mclk) i_arst_n = 1'b1;
        repeat (4) @(negedge i_mclk);
        dgram(1'b0, `DSPI_CMD_NOP, 16'h0000, 1'b0, 0, 2);
        dgram(1'b0, `DSPI_CMD_WR, 16'h4200, 1'b1, 2, 3);
        dgram(1'b0, `DSPI_CMD_RD, 16'h0120, 1'b0, 0, 2);
        dgram(1'b0, `DSPI_CMD_RDW, 16'h3400, 1'b1, 0, 4);
        for (int k = 0; k < 4; k++) begin
            rnd = $urandom;
            dgram(1'b0, k[0] ? `DSPI_CMD_RDW : `DSPI_CMD_WR, rnd[15:0], rnd[16], k, k + 1);
        end
        for (int c = 1; c < 8; c += 2)
            if (c != 3) dgram(1'b0, 3'(c), 16'h0155, c[2], 0, 2);
        master_u.open_frame(1'b0);
        master_u.send(8'h12, 5);
        master_u.close_frame();
        dgram(1'b0, `DSPI_CMD_WR, 16'h0155, 1'b0, 0, 1);
        dgram(1'b1, `DSPI_CMD_WR, 16'h0052, 1'b0, 0, 2);
        dgram(1'b1, `DSPI_CMD_RDW, 16'h0023, 1'b1, 1, 2);
        dgram(1'b1, `DSPI_CMD_NOP, 16'h0000, 1'b0, 0, 0);
        i_shared_bus_strap = 1'b1;
        repeat (8) @(negedge i_mclk);
        dgram(1'b1, `DSPI_CMD_WR, 16'h00A1, 1'b0, 0, 2);
        dgram(1'b1, `DSPI_CMD_RD, 16'h0030, 1'b0, 0, 2);
        dgram(1'b0, `DSPI_CMD_RDW, 16'h1234, 1'b1, 0, 2);
        i_shared_bus_strap = 1'b0;
        repeat (20) @(negedge i_mclk);
        chk(32'(exp_wr.size() + exp_rx.size()), 32'h0);
        chk(32'(wd_pd), 32'(exp_pd));
        chk(32'(wd_io), 32'(exp_io));
        stop_test();
    end
endmodule

bind dspi_top dspi_top_checker chk_u (.i_mclk, .i_arst_n, .i_shared_bus_strap,
    .i_main_port_select_n, .i_io_ctrl_select_n, .i_pd_event, .i_io_event, .o_main_serial_out,
    .o_io_ctrl_serial_out, .o_pd_rd, .o_pd_wr, .o_pd_addr, .o_pd_wdog_restart, .o_io_rd,
    .o_io_wr, .o_io_nop_seen);
